// >>> bench/shm_hub_monitor.sv
// port assertions for the sensor hub
`timescale 1ns/1ps
module shm_hub_monitor #(
  parameter QUARTER = 4
) (
  input wire clk,
  input wire rst,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  input wire accelPowered,
  input wire gyroPowered,
  input wire secondIrqIsInput,
  input wire firstIrqOut,
  input wire auxPullUpOn,
  input wire passThroughOn,
  input wire auxClockLineOe,
  input wire auxDataLineOe
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] lowCnt;
  // length of each scl low phase in clocks
  always @(posedge clk or posedge rst)
    if (rst) lowCnt <= 16'h0000;
    else lowCnt <= auxClockLineOe ? lowCnt + 16'h0001 : 16'h0000;
  pull_up_write_a: assert property ($changed(auxPullUpOn) |-> !s_axi_wready)
    else $error("pull-up moved outside a register write");
  pass_write_a: assert property ($changed(passThroughOn) |-> !s_axi_wready)
    else $error("pass-through moved outside a register write");
  irq_in_write_a: assert property ($changed(secondIrqIsInput) |-> !s_axi_wready)
    else $error("second pin direction moved outside a register write");
  pass_quiet_a: assert property (passThroughOn && $past(passThroughOn)
    |-> !auxClockLineOe && !auxDataLineOe)
    else $error("aux master active during pass-through");
  power_idle_a: assert property ((!accelPowered && !gyroPowered)[*4]
    |-> !auxClockLineOe && !auxDataLineOe)
    else $error("aux master active with both sensors down");
  irq_clear_a: assert property ($fell(firstIrqOut)
    |-> !s_axi_wready || $past(s_axi_arvalid && s_axi_arready))
    else $error("done pin fell without a read or write");
  irq_set_a: assert property ($rose(firstIrqOut)
    |-> !s_axi_wready || !auxClockLineOe && !auxDataLineOe)
    else $error("done pin rose before the bus was released");
  // first bit of each step waits two extra clocks for the step hand-off
  scl_low_a: assert property ($fell(auxClockLineOe)
    |-> lowCnt == 2 * QUARTER || lowCnt == 2 * QUARTER + 2)
    else $error("scl low phase has the wrong length");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000)
    else $error("read answer late or wider than a byte");
  cover property ($rose(firstIrqOut));
  cover property ($fell(firstIrqOut));
  cover property (passThroughOn && auxPullUpOn);
endmodule // shm_hub_monitor
bind shm_sensor_hub shm_hub_monitor #(.QUARTER(QUARTER)) hubMon (.*);

// >>> bench/shm_sensor_hub_test.sv
// self-checking bench for the sensor hub
`timescale 1ns/1ps
module shm_sensor_hub_test;
  localparam int QUARTER = 3; // 12 clocks, 48 ns per aux bit, plus the sync wait
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic accelPowered = 1'b0, gyroPowered = 1'b0, accelDataReady = 1'b0, secondIrqIn = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire secondIrqIsInput, firstIrqOut, auxPullUpOn, passThroughOn;
  wire auxClockLineOut, auxClockLineOe, auxDataLineOut, auxDataLineOe, s0Oe, s1Oe;
  // open-drain lines, pulled up inside or on the board
  wire auxClockLineIn = !auxClockLineOe;
  wire auxDataLineIn = !(auxDataLineOe | s0Oe | s1Oe);
  int failCount = 0, nChecks = 0, cycles = 0, h;
  logic [7:0] d;
  logic [1:0] r;
  logic [27:0] rows [0:17];
  logic [17:0] gate [0:3];
  shm_sensor_hub #(.QUARTER(QUARTER)) uut (.*);
  shm_sensor_model #(.ADDR(7'h1E)) s0 (.scl(auxClockLineIn), .sda(auxDataLineIn), .sdaOe(s0Oe));
  shm_sensor_model #(.ADDR(7'h20)) s1 (.scl(auxClockLineIn), .sda(auxDataLineIn), .sdaOe(s1Oe));
  always #2 clk = ~clk;
  task automatic closeOut;
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      failCount++;
      $display("[FAIL] run length expected under 90000 cycles seen more");
      closeOut;
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] dat, input logic [1:0] exp);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h000000, dat};
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    chk("write resp", s_axi_bresp, exp);
    s_axi_bready <= 1'b0;
    // one edge between transfers so a next call never re-drives in this step
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] dat, output logic [1:0] resp);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= {idx, 2'h0};
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    dat = s_axi_rdata[7:0];
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  // pulse long enough to pass the pin synchroniser
  task automatic trig(input logic ext);
    if (ext) secondIrqIn <= 1'b1;
    else accelDataReady <= 1'b1;
    repeat (4) @(posedge clk);
    secondIrqIn <= 1'b0;
    accelDataReady <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic cyc(input logic ext, input logic expDone);
    int n;
    trig(ext);
    n = 0;
    while (firstIrqOut !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk("done pin", firstIrqOut, expDone);
    if (firstIrqOut === 1'b1) begin
      rd(8'h53, d, r);
      chk("status", d, 8'h01);
      chk("pin after status read", firstIrqOut, 1'b0);
    end
  endtask
  initial begin
    rows = '{{8'h01, 8'h80, 8'h80, 4'h0}, {8'h02, 8'h3D, 8'h3D, 4'h0},
      {8'h03, 8'h10, 8'h10, 4'h0}, {8'h04, 8'h12, 8'h12, 4'h0}, {8'h05, 8'h41, 8'h41, 4'h0},
      {8'h06, 8'h40, 8'h40, 4'h0}, {8'h07, 8'hFF, 8'hC7, 4'h0}, {8'h07, 8'h01, 8'h01, 4'h0},
      {8'h0E, 8'h5A, 8'h5A, 4'h0}, {8'h19, 8'hFF, 8'h3F, 4'h0}, {8'h19, 8'h04, 8'h04, 4'h0},
      {8'h1A, 8'hFF, 8'hDF, 4'h0}, {8'h1A, 8'h00, 8'h00, 4'h0}, {8'h53, 8'hFF, 8'h00, 4'hC},
      {8'h20, 8'h11, 8'h00, 4'hF}, {8'h2E, 8'h11, 8'h00, 4'hC}, {8'h01, 8'h00, 8'h00, 4'h0},
      {8'h02, 8'h77, 8'h00, 4'hF}};
    gate = '{{8'h00, 8'h91, 2'h3}, {8'h04, 8'h80, 2'h3}, {8'h04, 8'h91, 2'h0},
      {8'h04, 8'h9D, 2'h3}};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 18; i++) begin
      wr(rows[i][27:20], rows[i][19:12], rows[i][3:2]);
      rd(rows[i][27:20], d, r);
      chk("reg read", d, rows[i][11:4]);
      chk("read resp", r, rows[i][1:0]);
    end
    s_axi_wstrb <= 4'h0;
    wr(8'h19, 8'h00, 2'h0);
    s_axi_wstrb <= 4'hF;
    rd(8'h19, d, r);
    chk("strobe-less write kept", d, 8'h04);
    $display("test register map done");
    accelPowered <= 1'b1;
    wr(8'h1A, 8'h81, 2'h0);
    repeat (50) @(posedge clk);
    chk("no start before trigger", auxClockLineOe, 1'b0);
    cyc(1'b0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      rd(8'h2E + i[7:0], d, r);
      chk("result", d, i == 0 ? 8'h2E : i == 1 ? 8'h2F : i == 2 ? 8'h60 : 8'h00);
    end
    $display("test accel trigger done");
    wr(8'h01, 8'h80, 2'h0);
    wr(8'h1A, 8'h91, 2'h0);
    chk("second pin input", secondIrqIsInput, 1'b1);
    for (int rt = 0; rt < 4; rt++) begin
      wr(8'h04, {rt[1:0], 6'h01}, 2'h0);
      h = s0.hits;
      for (int t = 0; t < 8; t++) cyc(1'b1, 1'b1);
      chk("decimated reads", s0.hits - h, 16 >> rt);
    end
    chk("second sensor left alone", s1.hits, 2);
    $display("test decimation done");
    wr(8'h04, 8'h09, 2'h0);
    wr(8'h0E, 8'hE2, 2'h0);
    h = s0.hits;
    cyc(1'b1, 1'b1);
    chk("aborted read", s0.hits - h, 2);
    wr(8'h0E, 8'h10, 2'h0);
    cyc(1'b1, 1'b1);
    chk("conditioned read", s0.hits - h, 6);
    wr(8'h02, 8'h3C, 2'h0);
    wr(8'h03, 8'h05, 2'h0);
    wr(8'h04, 8'h00, 2'h0);
    wr(8'h0E, 8'hA5, 2'h0);
    cyc(1'b1, 1'b1);
    chk("sensor written", s0.mem[5], 8'hA5);
    $display("test conditioned read and write done");
    for (int g = 0; g < 4; g++) begin
      wr(8'h19, gate[g][17:10], 2'h0);
      wr(8'h1A, gate[g][9:2], 2'h0);
      {accelPowered, gyroPowered} <= gate[g][1:0];
      h = s0.hits;
      trig(1'b0);
      cyc(1'b1, 1'b0);
      chk("gated hub quiet", s0.hits - h, 0);
    end
    chk("pull-up pin", auxPullUpOn, 1'b1);
    chk("pass pin", passThroughOn, 1'b1);
    $display("test gating done");
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h1A, d, r);
    chk("master after reset", d, 8'h00);
    chk("second pin after reset", secondIrqIsInput, 1'b0);
    chk("aux out levels", {auxClockLineOut, auxDataLineOut}, 2'b00);
    $display("test mid-run reset done");
    closeOut;
  end
endmodule // shm_sensor_hub_test

// >>> bench/shm_sensor_model.sv
// behavioural i2c sensor sitting on the aux lines
`timescale 1ns/1ps
module shm_sensor_model #(
  parameter logic [6:0] ADDR = 7'h1E
) (
  input wire logic scl,
  input wire logic sda,
  output logic sdaOe
);
  logic [7:0] mem [0:255];
  logic [7:0] sh;
  logic [7:0] ptr;
  logic act;
  logic rd;
  logic rdMode;
  int bitN;
  int byteIdx;
  int hits;
  initial begin
    sdaOe = 1'b0;
    act = 1'b0;
    rd = 1'b0;
    hits = 0;
    ptr = 8'h00;
    // contents differ per sensor; one register per sensor reads zero
    for (int i = 0; i < 256; i++) mem[i] = i[7:0] + {1'b0, ADDR};
  end
  // start or repeated start; the pointer survives a repeated start
  always @(negedge sda) if (scl) begin
    act = 1'b1;
    rd = 1'b0;
    rdMode = 1'b0;
    bitN = 0;
    byteIdx = 0;
    sdaOe = 1'b0;
  end
  always @(posedge sda) if (scl) begin
    act = 1'b0;
    sdaOe = 1'b0;
  end
  always @(posedge scl) if (act) begin
    if (bitN < 8 && !rd) sh = {sh[6:0], sda};
    if (bitN == 8 && rd && sda) act = 1'b0;
    bitN++;
  end
  // all line changes happen with scl low, so no false start or stop
  always @(negedge scl) if (act) begin
    sdaOe = 1'b0;
    if (bitN == 8 && !rd) begin
      sdaOe = 1'b1;
      if (byteIdx == 0) begin
        if (sh[7:1] == ADDR) begin
          rdMode = sh[0];
          hits++;
        end else begin
          sdaOe = 1'b0;
          act = 1'b0;
        end
      end else if (byteIdx == 1) ptr = sh;
      else begin
        mem[ptr] = sh;
        ptr++;
      end
    end
    if (bitN == 9) begin
      bitN = 0;
      byteIdx++;
      rd = rdMode;
      if (rd) begin
        sh = mem[ptr];
        ptr++;
      end
    end
    if (rd && bitN < 8) sdaOe = !sh[7 - bitN];
  end
endmodule // shm_sensor_model

// >>> hw/shm_defines.vh
// constants and register map of the sensor hub i2c master
`ifndef SHM_DEFINES_VH
`define SHM_DEFINES_VH
`define SHM_IDX_BANK 8'h01
`define SHM_IDX_SLV_FIRST 8'h02
`define SHM_IDX_WRDATA 8'h0E
`define SHM_IDX_CTRL10 8'h19
`define SHM_IDX_MASTER 8'h1A
`define SHM_IDX_RESULT 8'h2E
`define SHM_IDX_STATUS 8'h53
`define SHM_RESULT_COUNT 5'd18
`define SHM_REG_RESET 8'h00
`define SHM_CTRL10_MASK 8'h3F
`define SHM_MASTER_MASK 8'hDF
`define SHM_SLVN_CFG_MASK 8'hC7
`define SHM_BANK_BIT 7
`define SHM_EMBEDDED_FEATURES_ON_BIT 2
`define SHM_MASTER_ON_BIT 0
`define SHM_PASS_BIT 2
`define SHM_PULLUP_BIT 3
`define SHM_TRIG_SEL_BIT 4
`define SHM_IRQ1_BIT 7
`define SHM_RW_BIT 0
`define SHM_SRC_MODE_BIT 3
`define SHM_RATE_MSB 7
`define SHM_RATE_LSB 6
`define SHM_COUNT_MSB 5
`define SHM_COUNT_LSB 4
`define SHM_NUMOP_MSB 2
`define SHM_NUMOP_LSB 0
`define SHM_RESP_OKAY 2'b00
`define SHM_RESP_DECERR 2'b11
`define SHM_CLK_HZ 250000000
`define SHM_SCL_HZ 400000
`define SHM_QUARTER_CYCLES ((`SHM_CLK_HZ + 4 * `SHM_SCL_HZ - 1) / (4 * `SHM_SCL_HZ))
`endif

// >>> hw/shm_sensor_hub.v
// sensor hub: axi4-lite registers, trigger logic and aux i2c master
`timescale 1ns/1ps
`include "shm_defines.vh"
module shm_sensor_hub #(
  parameter QUARTER = `SHM_QUARTER_CYCLES
) (
  input wire clk,
  input wire rst,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [9:0] s_axi_awaddr,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  output reg [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  input wire [9:0] s_axi_araddr,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  input wire accelPowered,
  input wire gyroPowered,
  input wire accelDataReady,
  input wire secondIrqIn,
  output wire secondIrqIsInput,
  output wire firstIrqOut,
  output wire auxPullUpOn,
  output wire passThroughOn,
  input wire auxClockLineIn,
  output wire auxClockLineOut,
  output reg auxClockLineOe,
  input wire auxDataLineIn,
  output wire auxDataLineOut,
  output reg auxDataLineOe
);
  localparam S_IDLE = 4'd0;
  localparam S_SELECT = 4'd1;
  localparam S_START = 4'd2;
  localparam S_ADRW = 4'd3;
  localparam S_SUB = 4'd4;
  localparam S_WDATA = 4'd5;
  localparam S_RSTART = 4'd6;
  localparam S_ADRR = 4'd7;
  localparam S_READ = 4'd8;
  localparam S_STOP = 4'd9;
  localparam S_DONE = 4'd10;
  localparam P_START = 2'd0;
  localparam P_WRITE = 2'd1;
  localparam P_READ = 2'd2;
  localparam P_STOP = 2'd3;

  function [7:0] slvIdx;
    input [1:0] n;
    input [1:0] k;
    begin
      slvIdx = `SHM_IDX_SLV_FIRST + {5'h00, n, 1'b0} + {6'h00, n} + {6'h00, k};
    end
  endfunction

  function [2:0] decimMask;
    input [1:0] rate;
    begin
      case (rate)
        2'b00: decimMask = 3'h0;
        2'b01: decimMask = 3'h1;
        2'b10: decimMask = 3'h3;
        default: decimMask = 3'h7;
      endcase
    end
  endfunction

  integer i;
  integer wi;
  integer ri;
  integer fi;
  reg [7:0] bankReg;
  reg [7:0] ctrlTen;
  reg [7:0] masterCfg;
  reg [7:0] wrData;
  reg [7:0] slvAddr [0:3];
  reg [7:0] slvSub [0:3];
  reg [7:0] slvCfg [0:3];
  reg [7:0] results [0:17];
  reg doneFlag;
  reg doneSet;
  reg awHave;
  reg wHave;
  reg [7:0] awIdx;
  reg [7:0] wByte;
  reg wLane;
  reg wrOk;
  reg rdOk;
  reg [7:0] rdByte;
  wire [7:0] arIdx = s_axi_araddr[9:2];
  wire bankOn = bankReg[`SHM_BANK_BIT];

  assign s_axi_awready = !awHave && !s_axi_bvalid;
  assign s_axi_wready = !wHave && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire statusRead = s_axi_arvalid && !s_axi_rvalid && arIdx == `SHM_IDX_STATUS;

  // write decode; slave bank hidden unless selected
  always @* begin
    wrOk = (awIdx == `SHM_IDX_BANK) || (awIdx == `SHM_IDX_CTRL10) ||
      (awIdx == `SHM_IDX_MASTER) || (bankOn && awIdx == `SHM_IDX_WRDATA);
    for (wi = 0; wi < 4; wi = wi + 1) begin
      if (bankOn && (awIdx == slvIdx(wi[1:0], 2'd0) || awIdx == slvIdx(wi[1:0], 2'd1) ||
          awIdx == slvIdx(wi[1:0], 2'd2))) begin
        wrOk = 1'b1;
      end
    end
  end

  // read decode; results and status read-only
  always @* begin
    rdOk = 1'b1;
    rdByte = 8'h00;
    if (arIdx == `SHM_IDX_BANK) begin
      rdByte = bankReg;
    end else if (arIdx == `SHM_IDX_CTRL10) begin
      rdByte = ctrlTen;
    end else if (arIdx == `SHM_IDX_MASTER) begin
      rdByte = masterCfg;
    end else if (arIdx == `SHM_IDX_STATUS) begin
      rdByte = {7'h00, doneFlag};
    end else if (bankOn && arIdx == `SHM_IDX_WRDATA) begin
      rdByte = wrData;
    end else begin
      rdOk = 1'b0;
    end
    for (ri = 0; ri < 4; ri = ri + 1) begin
      if (bankOn && arIdx == slvIdx(ri[1:0], 2'd0)) begin
        rdOk = 1'b1;
        rdByte = slvAddr[ri];
      end
      if (bankOn && arIdx == slvIdx(ri[1:0], 2'd1)) begin
        rdOk = 1'b1;
        rdByte = slvSub[ri];
      end
      if (bankOn && arIdx == slvIdx(ri[1:0], 2'd2)) begin
        rdOk = 1'b1;
        rdByte = slvCfg[ri];
      end
    end
    for (ri = 0; ri < 18; ri = ri + 1) begin
      if (arIdx == `SHM_IDX_RESULT + ri[7:0]) begin
        rdOk = 1'b1;
        rdByte = results[ri];
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      awHave <= 1'b0;
      wHave <= 1'b0;
      awIdx <= 8'h00;
      wByte <= 8'h00;
      wLane <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SHM_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SHM_RESP_OKAY;
      bankReg <= `SHM_REG_RESET;
      ctrlTen <= `SHM_REG_RESET;
      masterCfg <= `SHM_REG_RESET;
      wrData <= `SHM_REG_RESET;
      for (i = 0; i < 4; i = i + 1) begin
        slvAddr[i] <= `SHM_REG_RESET;
        slvSub[i] <= `SHM_REG_RESET;
        slvCfg[i] <= `SHM_REG_RESET;
      end
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave <= 1'b1;
        awIdx <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave <= 1'b1;
        wByte <= s_axi_wdata[7:0];
        wLane <= s_axi_wstrb[0];
      end
      if (awHave && wHave && !s_axi_bvalid) begin
        awHave <= 1'b0;
        wHave <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrOk ? `SHM_RESP_OKAY : `SHM_RESP_DECERR;
        if (wrOk && wLane) begin
          if (awIdx == `SHM_IDX_BANK) bankReg <= wByte;
          if (awIdx == `SHM_IDX_CTRL10) ctrlTen <= wByte & `SHM_CTRL10_MASK;
          if (awIdx == `SHM_IDX_MASTER) masterCfg <= wByte & `SHM_MASTER_MASK;
          if (awIdx == `SHM_IDX_WRDATA) wrData <= wByte;
          for (i = 0; i < 4; i = i + 1) begin
            if (awIdx == slvIdx(i[1:0], 2'd0)) slvAddr[i] <= wByte;
            if (awIdx == slvIdx(i[1:0], 2'd1)) slvSub[i] <= wByte;
            // only slave 0 carries sensor count and source mode
            if (awIdx == slvIdx(i[1:0], 2'd2)) begin
              slvCfg[i] <= (i == 0) ? wByte : (wByte & `SHM_SLVN_CFG_MASK);
            end
          end
        end
      end
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rdByte};
        s_axi_rresp <= rdOk ? `SHM_RESP_OKAY : `SHM_RESP_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // set beats the read-clear in the same cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      doneFlag <= 1'b0;
    end else if (doneSet) begin
      doneFlag <= 1'b1;
    end else if (statusRead) begin
      doneFlag <= 1'b0;
    end
  end

  wire funcOn = ctrlTen[`SHM_EMBEDDED_FEATURES_ON_BIT];
  wire masterOn = masterCfg[`SHM_MASTER_ON_BIT];
  wire trigSel = masterCfg[`SHM_TRIG_SEL_BIT];
  wire passOn = masterCfg[`SHM_PASS_BIT];
  // master yields the aux lines while they are shorted to the host bus
  wire hubOn = funcOn && masterOn && !passOn && (accelPowered || gyroPowered) &&
    (trigSel || accelPowered);
  assign secondIrqIsInput = masterOn && trigSel;
  assign firstIrqOut = doneFlag && masterCfg[`SHM_IRQ1_BIT];
  assign auxPullUpOn = masterCfg[`SHM_PULLUP_BIT];
  assign passThroughOn = passOn;
  assign auxClockLineOut = 1'b0;
  assign auxDataLineOut = 1'b0;

  // pin synchronisers: change accepted once second and third stages agree
  reg [2:0] sclSync;
  reg [2:0] sdaSync;
  reg [2:0] irqSync;
  reg sclSeen;
  reg sdaSeen;
  reg extLevel;
  reg extPrev;
  reg accelPrev;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sclSync <= 3'b111;
      sdaSync <= 3'b111;
      irqSync <= 3'b000;
      sclSeen <= 1'b1;
      sdaSeen <= 1'b1;
      extLevel <= 1'b0;
      extPrev <= 1'b0;
      accelPrev <= 1'b0;
    end else begin
      sclSync <= {sclSync[1:0], auxClockLineIn};
      sdaSync <= {sdaSync[1:0], auxDataLineIn};
      irqSync <= {irqSync[1:0], secondIrqIn};
      if (sclSync[1] == sclSync[2]) sclSeen <= sclSync[2];
      if (sdaSync[1] == sdaSync[2]) sdaSeen <= sdaSync[2];
      if (irqSync[1] == irqSync[2]) extLevel <= irqSync[2];
      extPrev <= extLevel;
      accelPrev <= accelDataReady;
    end
  end
  wire extRise = extLevel && !extPrev && secondIrqIsInput;
  wire accelRise = accelDataReady && !accelPrev;
  wire trig = trigSel ? extRise : accelRise;

  reg [3:0] state;
  reg [1:0] cur;
  reg [2:0] trigCnt;
  reg [2:0] curCount;
  reg [4:0] ptr;
  reg [2:0] readLeft;
  reg condPhase;
  reg condOk;
  reg engGo;
  reg engBusy;
  reg engDone;
  reg engNack;
  reg [7:0] engRx;
  wire [7:0] curAddr = slvAddr[cur];
  wire [7:0] curCfg = slvCfg[cur];
  wire [2:0] numop = curCfg[`SHM_NUMOP_MSB:`SHM_NUMOP_LSB];
  wire isWrite = (cur == 2'd0) && !curAddr[`SHM_RW_BIT];
  wire slvUsed = (cur == 2'd0) || curAddr[`SHM_RW_BIT];
  wire decimOk = (curCount & decimMask(curCfg[`SHM_RATE_MSB:`SHM_RATE_LSB])) == 3'h0;
  wire eligible = slvUsed && decimOk && (isWrite || numop != 3'h0);
  wire lastSlave = cur == slvCfg[0][`SHM_COUNT_MSB:`SHM_COUNT_LSB];

  // primitive and byte for the current step
  reg [1:0] stepPrim;
  reg [7:0] stepTx;
  always @* begin
    stepPrim = P_WRITE;
    stepTx = 8'h00;
    case (state)
      S_START, S_RSTART: stepPrim = P_START;
      S_ADRW: stepTx = {curAddr[7:1], 1'b0};
      S_SUB: stepTx = condPhase ? wrData : slvSub[cur];
      S_WDATA: stepTx = wrData;
      S_ADRR: stepTx = {curAddr[7:1], 1'b1};
      S_READ: stepPrim = P_READ;
      S_STOP: stepPrim = P_STOP;
      default: stepPrim = P_WRITE;
    endcase
  end
  wire stepAck = !condPhase && readLeft > 3'd1;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      cur <= 2'd0;
      trigCnt <= 3'h0;
      curCount <= 3'h0;
      ptr <= 5'd0;
      readLeft <= 3'h0;
      condPhase <= 1'b0;
      condOk <= 1'b0;
      engGo <= 1'b0;
      doneSet <= 1'b0;
      for (fi = 0; fi < 18; fi = fi + 1) results[fi] <= `SHM_REG_RESET;
    end else begin
      engGo <= 1'b0;
      doneSet <= 1'b0;
      if (!hubOn) begin
        state <= S_IDLE;
      end else begin
        case (state)
          S_IDLE: begin
            // triggers during a cycle are dropped; config is not latched, so a mid-cycle write affects the rest of the cycle
            if (trig) begin
              curCount <= trigCnt;
              trigCnt <= trigCnt + 3'h1;
              cur <= 2'd0;
              ptr <= 5'd0;
              state <= S_SELECT;
            end
          end
          S_SELECT: begin
            condOk <= 1'b0;
            if (eligible) begin
              condPhase <= (cur == 2'd0) && !isWrite && curCfg[`SHM_SRC_MODE_BIT];
              readLeft <= numop;
              state <= S_START;
              engGo <= 1'b1;
            end else if (lastSlave) begin
              state <= S_DONE;
            end else begin
              cur <= cur + 2'd1;
            end
          end
          S_START: if (engDone) begin
            state <= S_ADRW;
            engGo <= 1'b1;
          end
          S_ADRW: if (engDone) begin
            state <= engNack ? S_STOP : S_SUB;
            engGo <= 1'b1;
          end
          S_SUB: if (engDone) begin
            state <= engNack ? S_STOP : ((isWrite && !condPhase) ? S_WDATA : S_RSTART);
            engGo <= 1'b1;
          end
          S_WDATA: if (engDone) begin
            state <= S_STOP;
            engGo <= 1'b1;
          end
          S_RSTART: if (engDone) begin
            state <= S_ADRR;
            engGo <= 1'b1;
          end
          S_ADRR: if (engDone) begin
            state <= engNack ? S_STOP : S_READ;
            engGo <= 1'b1;
          end
          S_READ: if (engDone) begin
            engGo <= 1'b1;
            if (condPhase) begin
              condOk <= engRx != 8'h00;
              state <= S_STOP;
            end else begin
              // bytes past the last result slot are read but discarded
              if (ptr < `SHM_RESULT_COUNT) begin
                results[ptr] <= engRx;
                ptr <= ptr + 5'd1;
              end
              readLeft <= readLeft - 3'h1;
              state <= (readLeft == 3'h1) ? S_STOP : S_READ;
            end
          end
          S_STOP: if (engDone) begin
            if (condPhase && condOk) begin
              condPhase <= 1'b0;
              state <= S_START;
              engGo <= 1'b1;
            end else if (lastSlave) begin
              state <= S_DONE;
            end else begin
              cur <= cur + 2'd1;
              state <= S_SELECT;
            end
          end
          S_DONE: begin
            doneSet <= 1'b1;
            state <= S_IDLE;
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // bit engine: four quarters per bit, waits at quarter 2 for stretched clock
  reg [1:0] prim;
  reg [1:0] quarter;
  reg [3:0] bitIdx;
  reg [7:0] sh;
  reg ackOut;
  reg [15:0] divCnt;
  wire lastBit = bitIdx == 4'd8;
  wire bitVal = (prim == P_READ) ? (lastBit ? !ackOut : 1'b1) : (lastBit ? 1'b1 : sh[7]);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      engBusy <= 1'b0;
      engDone <= 1'b0;
      engNack <= 1'b0;
      engRx <= 8'h00;
      prim <= P_START;
      quarter <= 2'd0;
      bitIdx <= 4'd0;
      sh <= 8'h00;
      ackOut <= 1'b0;
      divCnt <= 16'h0000;
      auxClockLineOe <= 1'b0;
      auxDataLineOe <= 1'b0;
    end else begin
      engDone <= 1'b0;
      if (!hubOn) begin
        engBusy <= 1'b0;
        auxClockLineOe <= 1'b0;
        auxDataLineOe <= 1'b0;
      end else if (engGo) begin
        engBusy <= 1'b1;
        prim <= stepPrim;
        sh <= stepTx;
        ackOut <= stepAck;
        bitIdx <= 4'd0;
        quarter <= 2'd0;
        divCnt <= 16'h0000;
      end else if (engBusy) begin
        if (divCnt != QUARTER[15:0] - 16'h0001) begin
          divCnt <= divCnt + 16'h0001;
        end else if (!(quarter == 2'd2 && !sclSeen)) begin
          divCnt <= 16'h0000;
          quarter <= quarter + 2'd1;
          case (quarter)
            2'd0: begin
              if (prim == P_START) begin
                auxDataLineOe <= 1'b0;
              end else if (prim == P_STOP) begin
                auxClockLineOe <= 1'b1;
                auxDataLineOe <= 1'b1;
              end else begin
                auxClockLineOe <= 1'b1;
                auxDataLineOe <= !bitVal;
              end
            end
            2'd1: auxClockLineOe <= 1'b0;
            2'd2: begin
              if (prim == P_START) begin
                auxDataLineOe <= 1'b1;
              end else if (prim == P_STOP) begin
                auxDataLineOe <= 1'b0;
              end else if (lastBit) begin
                engNack <= sdaSeen;
              end else begin
                engRx <= {engRx[6:0], sdaSeen};
              end
            end
            default: begin
              if (prim != P_STOP) auxClockLineOe <= 1'b1;
              if (prim == P_START || prim == P_STOP || lastBit) begin
                engBusy <= 1'b0;
                engDone <= 1'b1;
              end else begin
                bitIdx <= bitIdx + 4'd1;
                sh <= {sh[6:0], 1'b0};
              end
            end
          endcase
        end
      end
    end
  end
endmodule // shm_sensor_hub
